// ===== verilog/pcc_dev.sv
// PLL configuration end: reconfiguration store, phase stepping, startup.
//
// Functional notes
// - Enabled write stores data at address.
// - Unused write strobe held low by fabric.
// - Every access qualified by port enable.
// - Port runs on reconfiguration reference clock.
// - All signals active high except rst_b.
// - Output dividers 2 to 511, default 2.
// - Output phase -360 to 360, default 0.
// - Duty 0.001 to 0.999, default 0.500.
// - Feedback multiplier 10 to 400, default 42.
// - Fraction 0..63 sixty-fourths, default zero.
// - Input predivider 1 to 123, default 1.
// - Interpolator select 00/01/10, 11 invalid.
// - Deskew delay 0 to 63, default 0.
// - Delay path true feedback, false primary.
// - Delay active only when enabled.
// - Negative hold needs feedback path, delay enabled.
// - Lock-wait stalls startup until lock.
// - Input period always supplied, up to 100ns.
// - Reference jitter 0 to 0.200 UI.
// - Ready pulse per access, read data.
// - Address and data zero when unused.
`timescale 1ns/10ps
`default_nettype none
module pcc_dev (
  // Clock, reset and freeze.
  input  wire logic        reconf_ref_clock,
  input  wire logic        rst_b,
  input  wire logic        clk_en,
  // Link to the fabric end.
  pcc_if.dev               bus,
  // Analog loop status and startup.
  input  wire logic        pll_locked,
  output logic             startup_stall,
  output logic             cfg_error,
  output logic             phase_step_inc,
  output logic             phase_step_pulse,
  output logic [8:0]       out_div0,
  output logic [8:0]       feedback_multiplier,
  output logic [5:0]       feedback_fraction,
  output logic [6:0]       input_predivider,
  output logic [7:0]       interp_source_sel,
  output logic [5:0]       deskew_delay_eff,
  output logic             deskew_on_feedback,
  output logic             negative_hold_mode
);
  // Whole state of the end in one record.
  typedef struct packed {
    logic [3:0][15:0] div;
    logic [3:0][15:0] phase;
    logic [3:0][15:0] duty;
    logic [15:0]      mult;
    logic [15:0]      fract;
    logic [15:0]      prediv;
    logic [15:0]      interp;
    logic [15:0]      deskew;
    logic [15:0]      misc;
    logic [15:0]      rdata;
    logic             rdy;
    logic             err;
    logic             lk_s1;
    logic             lk_s2;
    logic [1:0]       step_cnt;
    logic             step_busy;
    logic             step_inc;
    logic             step_pulse;
    logic             done;
    logic             stall;
    logic [5:0]       dly_eff;
  } pcc_dev_st_t;

  pcc_dev_st_t st_reg;
  pcc_dev_st_t st_next;
  logic        sel_ok;
  logic        wval_ok;
  logic [1:0]  oi;

  // Decode, range check, stepping and startup logic.
  always_comb begin
    st_next = st_reg;
    sel_ok = 1'b1;
    wval_ok = 1'b1;
    oi = bus.reconf_addr[1:0];
    st_next.rdy = 1'b0;
    st_next.done = 1'b0;
    st_next.step_pulse = 1'b0;
    // Address readback for mapped words; unmapped addresses read zero.
    unique case (bus.reconf_addr[6:2])
      5'h00: st_next.rdata = st_reg.div[oi];
      5'h01: st_next.rdata = st_reg.phase[oi];
      5'h02: st_next.rdata = st_reg.duty[oi];
      5'h03: begin
        unique case (oi)
          2'h0: st_next.rdata = st_reg.mult;
          2'h1: st_next.rdata = st_reg.fract;
          2'h2: st_next.rdata = st_reg.prediv;
          2'h3: st_next.rdata = st_reg.interp;
        endcase
      end
      5'h04: begin
        sel_ok = (oi == 2'h0) || (oi == 2'h1);
        st_next.rdata = (oi == 2'h0) ? st_reg.deskew :
                        (oi == 2'h1) ? st_reg.misc : 16'h0000;
      end
      default: begin
        sel_ok = 1'b0;
        st_next.rdata = 16'h0000;
      end
    endcase
    // Write value checks against the allowed ranges.
    unique case (bus.reconf_addr[6:2])
      5'h00: wval_ok = (bus.reconf_write_data >= pcc_pkg::OUT_DIV_MIN) &&
                       (bus.reconf_write_data <= pcc_pkg::OUT_DIV_MAX);
      5'h01: wval_ok = ($signed(bus.reconf_write_data) <=
                        $signed(pcc_pkg::PHASE_MAX)) &&
                       ($signed(bus.reconf_write_data) >=
                        $signed(pcc_pkg::PHASE_MIN));
      5'h02: wval_ok = (bus.reconf_write_data >= pcc_pkg::DUTY_MIN) &&
                       (bus.reconf_write_data <= pcc_pkg::DUTY_MAX);
      5'h03: begin
        unique case (oi)
          2'h0: wval_ok = (bus.reconf_write_data >= pcc_pkg::MULT_MIN) &&
                          (bus.reconf_write_data <= pcc_pkg::MULT_MAX);
          2'h1: wval_ok = bus.reconf_write_data <= pcc_pkg::FRACT_MAX;
          2'h2: wval_ok = (bus.reconf_write_data >= pcc_pkg::PREDIV_MIN) &&
                         (bus.reconf_write_data <= pcc_pkg::PREDIV_MAX);
          2'h3: wval_ok = (bus.reconf_write_data[1:0] != pcc_pkg::SRC_BAD) &&
                          (bus.reconf_write_data[3:2] != pcc_pkg::SRC_BAD) &&
                          (bus.reconf_write_data[5:4] != pcc_pkg::SRC_BAD) &&
                          (bus.reconf_write_data[7:6] != pcc_pkg::SRC_BAD);
        endcase
      end
      default: wval_ok = 1'b1;
    endcase
    // Enabled access answers with ready; an enabled write with legal address and value stores data.
    if (bus.reconf_port_enable) begin
      st_next.rdy = 1'b1;
      if (bus.reconf_write_strobe) begin
        if (sel_ok && wval_ok) begin
          unique case (bus.reconf_addr[6:2])
            5'h00: st_next.div[oi] = bus.reconf_write_data;
            5'h01: st_next.phase[oi] = bus.reconf_write_data;
            5'h02: st_next.duty[oi] = bus.reconf_write_data;
            5'h03: begin
              unique case (oi)
                2'h0: st_next.mult = bus.reconf_write_data;
                2'h1: st_next.fract = bus.reconf_write_data;
                2'h2: st_next.prediv = bus.reconf_write_data;
                2'h3: st_next.interp = {8'h00, bus.reconf_write_data[7:0]};
              endcase
            end
            default: begin
              if (oi == 2'h0)
                st_next.deskew = {8'h00, bus.reconf_write_data[7:0]};
              else
                st_next.misc = {14'h0000, bus.reconf_write_data[1:0]};
            end
          endcase
          st_next.rdata = bus.reconf_write_data;
        end else begin
          st_next.err = 1'b1;
        end
      end
    end
    // Negative hold mode needs feedback path with delay enabled.
    if (st_next.misc[pcc_pkg::MISC_NEGATIVE_HOLD_MODE_BIT] &&
        !(st_next.deskew[pcc_pkg::DSK_PATH_BIT] &&
          st_next.deskew[pcc_pkg::DSK_EN_BIT])) begin
      st_next.err = 1'b1;
    end
    // Effective delay is registered so the output leaves a flip-flop.
    st_next.dly_eff = st_next.deskew[pcc_pkg::DSK_EN_BIT] ?
                      st_next.deskew[5:0] : 6'h00;
    // One phase step is taken, served, then answered with done.
    if (st_reg.step_busy) begin
      if (st_reg.step_cnt == 2'h0) begin
        st_next.step_busy = 1'b0;
        st_next.done = 1'b1;
      end else begin
        st_next.step_cnt = st_reg.step_cnt - 2'h1;
      end
    end else if (bus.phase_step_enable) begin
      st_next.step_busy = 1'b1;
      st_next.step_cnt = pcc_pkg::STEP_LAT;
      st_next.step_inc = bus.phase_step_direction;
      st_next.step_pulse = 1'b1;
    end
    // Lock synchroniser and startup stall.
    st_next.lk_s1 = pll_locked;
    st_next.lk_s2 = st_reg.lk_s1;
    st_next.stall = st_reg.misc[pcc_pkg::MISC_LWAIT_BIT] &&
                    !st_reg.lk_s2;
  end

  // State register, frozen while clock enable is low.
  always_ff @(posedge reconf_ref_clock or negedge rst_b) begin
    if (!rst_b) begin
      st_reg <= '0;
      for (int i = 0; i < pcc_pkg::NUM_OUT; i++) begin
        st_reg.div[i] <= pcc_pkg::OUT_DIV_RST;
        st_reg.phase[i] <= pcc_pkg::PHASE_RST;
        st_reg.duty[i] <= pcc_pkg::DUTY_RST;
      end
      st_reg.mult <= pcc_pkg::MULT_RST;
      st_reg.prediv <= pcc_pkg::PREDIV_RST;
    end else if (clk_en) begin
      st_reg <= st_next;
    end
  end

  // Outputs straight from state.
  assign bus.reconf_read_data = st_reg.rdata;
  assign bus.reconf_ready = st_reg.rdy;
  assign bus.phase_step_done = st_reg.done;
  assign startup_stall = st_reg.stall;
  assign cfg_error = st_reg.err;
  assign phase_step_inc = st_reg.step_inc;
  assign phase_step_pulse = st_reg.step_pulse;
  assign out_div0 = st_reg.div[0][8:0];
  assign feedback_multiplier = st_reg.mult[8:0];
  assign feedback_fraction = st_reg.fract[5:0];
  assign input_predivider = st_reg.prediv[6:0];
  assign interp_source_sel = st_reg.interp[7:0];
  assign deskew_delay_eff = st_reg.dly_eff;
  assign deskew_on_feedback = st_reg.deskew[pcc_pkg::DSK_PATH_BIT];
  assign negative_hold_mode = st_reg.misc[pcc_pkg::MISC_NEGATIVE_HOLD_MODE_BIT];
endmodule : pcc_dev
`default_nettype wire

// ===== verilog/pcc_pkg.sv
// Package of constants shared by the PLL configuration port ends.
`default_nettype none
package pcc_pkg;
  // Port widths and output count.
  localparam int ADDR_W = 7;
  localparam int DATA_W = 16;
  localparam int NUM_OUT = 4;
  // Configuration word addresses.
  localparam logic [6:0] A_OUT_DIV0   = 7'h00;
  localparam logic [6:0] A_OUT_PHASE0 = 7'h04;
  localparam logic [6:0] A_OUT_DUTY0  = 7'h08;
  localparam logic [6:0] A_FB_MULT    = 7'h0c;
  localparam logic [6:0] A_FB_FRACT   = 7'h0d;
  localparam logic [6:0] A_PREDIV     = 7'h0e;
  localparam logic [6:0] A_INTERP     = 7'h0f;
  localparam logic [6:0] A_DESKEW     = 7'h10;
  localparam logic [6:0] A_MISC       = 7'h11;
  // Field limits and reset values.
  localparam logic [15:0] OUT_DIV_MIN = 16'h0002;
  localparam logic [15:0] OUT_DIV_MAX = 16'h01ff;
  localparam logic [15:0] OUT_DIV_RST = 16'h0002;
  localparam logic [15:0] PHASE_MAX   = 16'h0168;
  localparam logic [15:0] PHASE_MIN   = 16'hfe98;
  localparam logic [15:0] PHASE_RST   = 16'h0000;
  localparam logic [15:0] DUTY_MIN    = 16'h0001;
  localparam logic [15:0] DUTY_MAX    = 16'h03e7;
  localparam logic [15:0] DUTY_RST    = 16'h01f4;
  localparam logic [15:0] MULT_MIN    = 16'h000a;
  localparam logic [15:0] MULT_MAX    = 16'h0190;
  localparam logic [15:0] MULT_RST    = 16'h002a;
  localparam logic [15:0] FRACT_MAX   = 16'h003f;
  localparam logic [15:0] PREDIV_MIN  = 16'h0001;
  localparam logic [15:0] PREDIV_MAX  = 16'h007b;
  localparam logic [15:0] PREDIV_RST  = 16'h0001;
  localparam logic [1:0]  SRC_NONE    = 2'h0;
  localparam logic [1:0]  SRC_DESKEW  = 2'h1;
  localparam logic [1:0]  SRC_PHASE   = 2'h2;
  localparam logic [1:0]  SRC_BAD     = 2'h3;
  localparam logic [5:0]  DLY_MAX     = 6'h3f;
  // Deskew word bit positions.
  localparam int DSK_PATH_BIT = 6;
  localparam int DSK_EN_BIT   = 7;
  // Misc word bit positions.
  localparam int MISC_NEGATIVE_HOLD_MODE_BIT = 0;
  localparam int MISC_LWAIT_BIT = 1;
  // Phase step countdown load; done follows enable by four cycles.
  localparam logic [1:0]  STEP_LAT    = 2'h2;
endpackage : pcc_pkg
`default_nettype wire

// ===== verilog/pcc_if.sv
// Interface joining the fabric end and the PLL configuration end.
`timescale 1ns/10ps
`default_nettype none
interface pcc_if;
  logic        reconf_write_strobe;
  logic        reconf_port_enable;
  logic [6:0]  reconf_addr;
  logic [15:0] reconf_write_data;
  logic [15:0] reconf_read_data;
  logic        reconf_ready;
  logic        phase_step_enable;
  logic        phase_step_direction;
  logic        phase_step_done;
  // PLL end.
  modport dev (input reconf_write_strobe, reconf_port_enable, reconf_addr,
               reconf_write_data, phase_step_enable, phase_step_direction,
               output reconf_read_data, reconf_ready, phase_step_done);
  // Fabric end.
  modport fab (output reconf_write_strobe, reconf_port_enable, reconf_addr,
               reconf_write_data, phase_step_enable, phase_step_direction,
               input reconf_read_data, reconf_ready, phase_step_done);
endinterface : pcc_if
`default_nettype wire

// ===== verilog/pcc_fab.sv
// Fabric end: drives reconfiguration accesses and phase steps.
`timescale 1ns/10ps
`default_nettype none
module pcc_fab (
  // Clock, reset and freeze.
  input  wire logic        reconf_ref_clock,
  input  wire logic        rst_b,
  input  wire logic        clk_en,
  // User request side.
  input  wire logic        req_valid,
  input  wire logic        req_write,
  input  wire logic [6:0]  req_addr,
  input  wire logic [15:0] req_data,
  output logic             req_busy,
  output logic             resp_valid,
  output logic [15:0]      resp_data,
  input  wire logic        step_req,
  input  wire logic        step_up,
  output logic             step_busy,
  output logic             step_finished,
  // Link to the PLL end.
  pcc_if.fab               bus
);
  // Whole state of the fabric end.
  typedef struct packed {
    logic        en;
    logic        we;
    logic [6:0]  addr;
    logic [15:0] wdata;
    logic        busy;
    logic        rv;
    logic [15:0] rd;
    logic        ps_en;
    logic        ps_dir;
    logic        ps_busy;
    logic        ps_fin;
  } pcc_fab_st_t;

  pcc_fab_st_t st_reg;
  pcc_fab_st_t st_next;

  // One access and one step outstanding at a time; idle access lines held at zero, step direction kept.
  always_comb begin
    st_next = st_reg;
    st_next.en = 1'b0;
    st_next.we = 1'b0;
    st_next.addr = 7'h00;
    st_next.wdata = 16'h0000;
    st_next.rv = 1'b0;
    st_next.ps_en = 1'b0;
    st_next.ps_fin = 1'b0;
    if (st_reg.busy) begin
      if (bus.reconf_ready) begin
        st_next.busy = 1'b0;
        st_next.rv = 1'b1;
        st_next.rd = bus.reconf_read_data;
      end
    end else if (req_valid) begin
      st_next.en = 1'b1;
      st_next.we = req_write;
      st_next.addr = req_addr;
      st_next.wdata = req_write ? req_data : 16'h0000;
      st_next.busy = 1'b1;
    end
    if (st_reg.ps_busy) begin
      if (bus.phase_step_done) begin
        st_next.ps_busy = 1'b0;
        st_next.ps_fin = 1'b1;
      end
    end else if (step_req) begin
      st_next.ps_en = 1'b1;
      st_next.ps_dir = step_up;
      st_next.ps_busy = 1'b1;
    end
  end

  // State register.
  always_ff @(posedge reconf_ref_clock or negedge rst_b) begin
    if (!rst_b) begin
      st_reg <= '0;
    end else if (clk_en) begin
      st_reg <= st_next;
    end
  end

  // Outputs straight from state.
  assign bus.reconf_port_enable = st_reg.en;
  assign bus.reconf_write_strobe = st_reg.we;
  assign bus.reconf_addr = st_reg.addr;
  assign bus.reconf_write_data = st_reg.wdata;
  assign bus.phase_step_enable = st_reg.ps_en;
  assign bus.phase_step_direction = st_reg.ps_dir;
  assign req_busy = st_reg.busy;
  assign resp_valid = st_reg.rv;
  assign resp_data = st_reg.rd;
  assign step_busy = st_reg.ps_busy;
  assign step_finished = st_reg.ps_fin;
endmodule : pcc_fab
`default_nettype wire

// ===== sim/pcc_chk.sv
// Checker of the wires between the fabric end and the PLL end.
`timescale 1ns/10ps
`default_nettype none
module pcc_chk (
  // Clock and reset.
  input wire logic        reconf_ref_clock,
  input wire logic        rst_b,
  // Reconfiguration wires.
  input wire logic        reconf_write_strobe,
  input wire logic        reconf_port_enable,
  input wire logic [6:0]  reconf_addr,
  input wire logic [15:0] reconf_write_data,
  input wire logic [15:0] reconf_read_data,
  input wire logic        reconf_ready,
  // Phase step wires.
  input wire logic        phase_step_enable,
  input wire logic        phase_step_direction,
  input wire logic        phase_step_done
);
  // Every property runs on the port clock and is off during reset.
  default clocking cb @(posedge reconf_ref_clock); endclocking
  default disable iff (!rst_b);
  ready_answer_a: assert property (reconf_port_enable |=> reconf_ready)
    else $error("ready missing after an enabled access");
  ready_cause_a: assert property (reconf_ready |-> $past(reconf_port_enable))
    else $error("ready without an enabled access");
  ready_pulse_a: assert property (reconf_ready |=> !reconf_ready)
    else $error("ready longer than one cycle");
  strobe_qual_a: assert property (reconf_write_strobe |-> reconf_port_enable)
    else $error("write strobe without port enable");
  idle_zero_a: assert property (!reconf_port_enable |-> !reconf_write_strobe
    && reconf_addr == 7'h00 && reconf_write_data == 16'h0000)
    else $error("idle port lines not zero");
  write_echo_a: assert property (reconf_port_enable && reconf_write_strobe
    && reconf_addr == pcc_pkg::A_FB_MULT
    && reconf_write_data >= pcc_pkg::MULT_MIN
    && reconf_write_data <= pcc_pkg::MULT_MAX
    |=> reconf_read_data == $past(reconf_write_data))
    else $error("stored word not returned");
  step_latency_a: assert property (phase_step_enable
    |-> ##1 !phase_step_done [*3] ##1 phase_step_done)
    else $error("step done not four cycles after enable");
  step_cause_a: assert property (phase_step_done |-> $past(phase_step_enable, 4))
    else $error("step done without a step");
  step_gap_a: assert property (phase_step_enable |=> !phase_step_enable [*4])
    else $error("step requested before done");
  dir_held_a: assert property (phase_step_enable
    |=> $stable(phase_step_direction) [*4])
    else $error("step direction moved during a step");
  // Main scenarios.
  cover property (reconf_port_enable && reconf_write_strobe);
  cover property (reconf_port_enable && !reconf_write_strobe);
  cover property (phase_step_enable && phase_step_direction);
  cover property (phase_step_enable && !phase_step_direction);
endmodule // pcc_chk
`default_nettype wire

// ===== sim/pll_config_and_control_port_tb.sv
// Testbench joining both ends of the PLL configuration port.
`timescale 1ns/10ps
`default_nettype none
module pll_config_and_control_port_tb;
  logic        sys_clk, rst_b, clk_en, pll_locked, req_valid, req_write;
  logic        step_req, step_up, req_busy, resp_valid, step_busy;
  logic        step_finished, startup_stall, cfg_error, phase_step_inc;
  logic        phase_step_pulse, deskew_on_feedback, negative_hold_mode;
  logic [6:0]  req_addr, input_predivider;
  logic [15:0] req_data, resp_data, d;
  logic [8:0]  out_div0, feedback_multiplier;
  logic [5:0]  feedback_fraction, deskew_delay_eff;
  logic [7:0]  interp_source_sel;
  logic [16:0] exp_q[$];
  logic [16:0] ev;
  int          fails, samples_checked, n_pulse;
  // Legal edge values and refused values with the word that must stay.
  logic [22:0] ok_t[10] = '{{7'h00, 16'h0002}, {7'h00, 16'h01ff},
    {7'h04, 16'h0168}, {7'h04, 16'hfe98}, {7'h08, 16'h0001},
    {7'h08, 16'h03e7}, {7'h0c, 16'h000a}, {7'h0c, 16'h0190},
    {7'h0d, 16'h003f}, {7'h0e, 16'h007b}};
  logic [38:0] bad_t[8] = '{{7'h00, 16'h0001, 16'h0002},
    {7'h00, 16'h0200, 16'h0002}, {7'h0c, 16'h0009, 16'h0190},
    {7'h0c, 16'h0191, 16'h0190}, {7'h0e, 16'h0000, 16'h007b},
    {7'h0e, 16'h007c, 16'h007b}, {7'h0f, 16'h0003, 16'h00aa},
    {7'h12, 16'h1234, 16'h0000}};
  pcc_if link ();
  pcc_dev pcc_dev_inst (.reconf_ref_clock(sys_clk), .rst_b, .clk_en,
    .bus(link), .pll_locked, .startup_stall, .cfg_error, .phase_step_inc,
    .phase_step_pulse, .out_div0, .feedback_multiplier, .feedback_fraction,
    .input_predivider, .interp_source_sel, .deskew_delay_eff,
    .deskew_on_feedback, .negative_hold_mode);
  pcc_fab pcc_fab_inst (.reconf_ref_clock(sys_clk), .rst_b, .clk_en,
    .req_valid, .req_write, .req_addr, .req_data, .req_busy, .resp_valid,
    .resp_data, .step_req, .step_up, .step_busy, .step_finished, .bus(link));
  pcc_chk pcc_chk_inst (.reconf_ref_clock(sys_clk), .rst_b,
    .reconf_write_strobe(link.reconf_write_strobe),
    .reconf_port_enable(link.reconf_port_enable),
    .reconf_addr(link.reconf_addr),
    .reconf_write_data(link.reconf_write_data),
    .reconf_read_data(link.reconf_read_data),
    .reconf_ready(link.reconf_ready),
    .phase_step_enable(link.phase_step_enable),
    .phase_step_direction(link.phase_step_direction),
    .phase_step_done(link.phase_step_done));
  // Clock at 40 MHz.
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  // Compares one value and counts the outcome.
  task chk(input string what, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      fails++;
      $display("BAD %s expected %h seen %h", what, e, g);
    end
  endtask
  // Prints the counts and the verdict, then ends the run.
  task finish_test;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // One user request; the expected answer goes on the queue.
  task rq(input logic w, input logic [6:0] a, input logic [15:0] dt,
          input logic [16:0] e);
    int n;
    @(posedge sys_clk);
    req_valid <= 1'b1;
    req_write <= w;
    req_addr <= a;
    req_data <= dt;
    @(posedge sys_clk);
    req_valid <= 1'b0;
    exp_q.push_back(e);
    n = 0;
    @(negedge sys_clk);
    while (req_busy !== 1'b0 && n < 50) begin
      n++;
      @(negedge sys_clk);
    end
    if (n == 50) fails++;
  endtask
  // Write with a known answer, or with the answer left open.
  task wr(input logic [6:0] a, input logic [15:0] dt, input logic ok);
    rq(1'b1, a, dt, ok ? {1'b0, dt} : 17'h10000);
  endtask
  // One phase step, then its direction is compared.
  task st(input logic up);
    int n;
    int p;
    p = n_pulse;
    @(posedge sys_clk);
    step_req <= 1'b1;
    step_up <= up;
    @(posedge sys_clk);
    step_req <= 1'b0;
    n = 0;
    @(negedge sys_clk);
    while (step_finished !== 1'b1 && n < 20) begin
      n++;
      @(negedge sys_clk);
    end
    if (n == 20) fails++;
    chk("phase_step_inc", {15'h0, up}, {15'h0, phase_step_inc});
    chk("direction", {15'h0, up}, {15'h0, link.phase_step_direction});
    chk("step_pulse", 16'h0001, 16'(n_pulse - p));
    chk("step_busy", 16'h0000, {15'h0, step_busy});
  endtask
  // Takes the oldest note whenever a response appears.
  always @(negedge sys_clk) begin
    if (resp_valid === 1'b1) begin
      if (exp_q.size() == 0) begin
        fails++;
        $display("BAD resp_data expected none seen %h", resp_data);
      end else begin
        ev = exp_q.pop_front();
        if (ev[16] === 1'b0) chk("resp_data", ev[15:0], resp_data);
      end
    end
  end
  // Counts the one-cycle pulses that mark a taken phase step.
  always @(negedge sys_clk) begin
    if (phase_step_pulse === 1'b1) n_pulse++;
  end
  // Cuts a hang short.
  initial begin
    repeat (5000) @(posedge sys_clk);
    fails++;
    finish_test;
  end
  // Main sequence.
  initial begin
    fails = 0;
    samples_checked = 0;
    n_pulse = 0;
    {rst_b, pll_locked, req_valid, req_write, step_req, step_up} = 6'h00;
    clk_en = 1'b1;
    req_addr = 7'h00;
    req_data = 16'h0000;
    void'($urandom(32'h1f1c));
    repeat (4) @(posedge sys_clk);
    rst_b <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      rq(1'b0, 7'(i), 16'h0, {1'b0, pcc_pkg::OUT_DIV_RST});
      rq(1'b0, 7'(4 + i), 16'h0, {1'b0, pcc_pkg::PHASE_RST});
      rq(1'b0, 7'(8 + i), 16'h0, {1'b0, pcc_pkg::DUTY_RST});
    end
    rq(1'b0, pcc_pkg::A_FB_MULT, 16'h0, {1'b0, pcc_pkg::MULT_RST});
    rq(1'b0, pcc_pkg::A_FB_FRACT, 16'h0, 17'h0);
    rq(1'b0, pcc_pkg::A_PREDIV, 16'h0, {1'b0, pcc_pkg::PREDIV_RST});
    rq(1'b0, pcc_pkg::A_INTERP, 16'h0, 17'h0);
    rq(1'b0, pcc_pkg::A_DESKEW, 16'h0, 17'h0);
    chk("out_div0", 16'h0002, {7'h0, out_div0});
    chk("mult", 16'h002a, {7'h0, feedback_multiplier});
    $display("test defaults done");
    foreach (ok_t[i]) begin
      wr(ok_t[i][22:16], ok_t[i][15:0], 1'b1);
      rq(1'b0, ok_t[i][22:16], 16'h0, {1'b0, ok_t[i][15:0]});
    end
    chk("fract", 16'h003f, {10'h0, feedback_fraction});
    chk("prediv", 16'h007b, {9'h0, input_predivider});
    repeat (8) begin
      d = 16'(2 + $urandom % 510);
      wr(pcc_pkg::A_OUT_DIV0, d, 1'b1);
      chk("out_div0", d, {7'h0, out_div0});
    end
    wr(pcc_pkg::A_OUT_DIV0, 16'h0002, 1'b1);
    // A request held while the clock enable is low must not be taken.
    @(posedge sys_clk);
    clk_en <= 1'b0;
    req_valid <= 1'b1;
    req_write <= 1'b1;
    req_addr <= pcc_pkg::A_OUT_DIV0;
    req_data <= 16'h0033;
    repeat (5) @(negedge sys_clk);
    chk("frozen_busy", 16'h0000, {15'h0, req_busy});
    chk("frozen_div", 16'h0002, {7'h0, out_div0});
    @(posedge sys_clk);
    req_valid <= 1'b0;
    clk_en <= 1'b1;
    $display("test clock enable freeze done");
    for (int c = 0; c < 3; c++) begin
      wr(pcc_pkg::A_INTERP, {8'h0, {4{2'(c)}}}, 1'b1);
      chk("interp", {8'h0, {4{2'(c)}}}, {8'h0, interp_source_sel});
    end
    $display("test settings done");
    wr(pcc_pkg::A_DESKEW, 16'h0055, 1'b1);
    chk("dly_off", 16'h0000, {10'h0, deskew_delay_eff});
    chk("path_fb", 16'h0001, {15'h0, deskew_on_feedback});
    wr(pcc_pkg::A_DESKEW, 16'h0095, 1'b1);
    chk("dly_on", 16'h0015, {10'h0, deskew_delay_eff});
    chk("path_pri", 16'h0000, {15'h0, deskew_on_feedback});
    wr(pcc_pkg::A_DESKEW, 16'h00d5, 1'b1);
    wr(pcc_pkg::A_MISC, 16'h0003, 1'b1);
    chk("negative_hold_mode", 16'h0001, {15'h0, negative_hold_mode});
    chk("cfg_ok", 16'h0000, {15'h0, cfg_error});
    chk("stall", 16'h0001, {15'h0, startup_stall});
    @(posedge sys_clk);
    pll_locked <= 1'b1;
    repeat (6) @(negedge sys_clk);
    chk("stall_off", 16'h0000, {15'h0, startup_stall});
    $display("test deskew and startup done");
    st(1'b1);
    st(1'b0);
    repeat (4) st(1'($urandom));
    $display("test phase steps done");
    foreach (bad_t[i]) begin
      wr(bad_t[i][38:32], bad_t[i][31:16], 1'b0);
      rq(1'b0, bad_t[i][38:32], 16'h0, {1'b0, bad_t[i][15:0]});
    end
    chk("cfg_error", 16'h0001, {15'h0, cfg_error});
    $display("test refused writes done");
    finish_test;
  end
endmodule // pll_config_and_control_port_tb
`default_nettype wire
